// ==== shared/pdcmc_pkg.sv ====
/*
 * pdcmc_pkg: constants and carriers for the power-down and
 * conversion-mode control block.
 * assumes a 125 MHz core clock; all timing figures are converted here.
 */
package pdcmc_pkg;

  localparam int unsigned CLK_MHZ         = 125;
  // conversion times in ns, build-time settings
  localparam int unsigned CONV_FAST_NS    = 1600;
  localparam int unsigned CONV_NORMAL_NS  = 1800;
  // fast-mode longest idle time between conversions, in ns
  localparam int unsigned IDLE_MAX_NS     = 10000;

  // least times round up, longest round down
  localparam int unsigned CONV_FAST_CYC   =
    (CONV_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_NORMAL_CYC =
    (CONV_NORMAL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IDLE_MAX_CYC    = (IDLE_MAX_NS * CLK_MHZ) / 1000;

  localparam int unsigned CNT_W           = 16;
  localparam int unsigned CFG_W           = 16;
  localparam int unsigned CFG_TIMING_BIT  = 1;
  localparam logic [15:0] CFG_RESET       = 16'hFFFF;
  localparam int unsigned CFG_BITS        = 16;

  typedef enum logic [1:0] {
    PDCMC_SLEEP = 2'b00,
    PDCMC_IDLE  = 2'b01,
    PDCMC_CONV  = 2'b10
  } pdcmc_state_e;

  // regulator and reference enables
  typedef struct packed {
    logic analog_regulator_output;
    logic digital_regulator_output;
    logic reference_regulator_output;
    logic reference_enable;
  } pdcmc_power_s;

  // configuration word written over the serial port
  typedef struct packed {
    logic             valid;
    logic [CFG_W-1:0] word;
  } pdcmc_cfg_s;

endpackage

// ==== design/pdcmc_sync.sv ====
/*
 * pdcmc_sync: two-flop synchroniser for one asynchronous level.
 * assumes i_clk is the core clock; output lags input by two edges.
 */
module pdcmc_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  import pdcmc_pkg::*;

  logic meta_ff;
  logic sync_ff;

  // reset high so sleep and reset hold while the chain fills
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// ==== design/pdcmc_ctrl.sv ====
/*
 * pdcmc_ctrl: power-state and conversion-timing control of the sampler.
 * assumes pins arrive unsynchronised; config words come from a serial
 * front end on i_clk as a one-cycle valid strobe.
 */
module pdcmc_ctrl (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_sleep_request_input,
  input  wire logic                    i_core_reset,
  input  wire logic                    i_sample_start_input,
  input  wire pdcmc_pkg::pdcmc_cfg_s   i_cfg,
  output logic                         o_conversion_active_output,
  output logic                         o_serial_enable,
  output logic                         o_data_out_oe_kill,
  output logic                         o_conversion_timing_select,
  output logic                         o_idle_overrun,
  output logic [15:0]                  o_cfg_active,
  output pdcmc_pkg::pdcmc_power_s      o_power
);
  import pdcmc_pkg::*;

  logic           sleep_s;
  logic           creset_s;
  logic           start_meta_ff;
  logic           start_s_ff;
  logic           start_d_ff;
  logic           sleep_d_ff;
  logic           creset_d_ff;
  pdcmc_state_e   state_ff;
  pdcmc_state_e   nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] idle_ff;
  logic [CFG_W-1:0] cfg_ff;
  logic [CFG_W-1:0] pend_ff;
  logic           pend_vld_ff;
  logic           overrun_ff;
  logic           busy_ff;
  logic           kill_ff;

  pdcmc_sync u_sync_sleep (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_sleep_request_input),
    .o_sync  (sleep_s)
  );

  pdcmc_sync u_sync_reset (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_core_reset),
    .o_sync  (creset_s)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      start_meta_ff <= 1'b0;
      start_s_ff    <= 1'b0;
      start_d_ff    <= 1'b0;
      sleep_d_ff    <= 1'b1;
      creset_d_ff   <= 1'b1;
    end else begin
      start_meta_ff <= i_sample_start_input;
      start_s_ff    <= start_meta_ff;
      start_d_ff    <= start_s_ff;
      sleep_d_ff    <= sleep_s;
      creset_d_ff   <= creset_s;
    end
  end

  wire start_rise  = start_s_ff & ~start_d_ff;
  wire abort_rise  = (sleep_s & ~sleep_d_ff) | (creset_s & ~creset_d_ff);
  wire hold_off    = sleep_s | creset_s;
  wire timing_sel  = cfg_ff[CFG_TIMING_BIT];
  wire [CNT_W-1:0] conv_len = timing_sel ?
    CNT_W'(CONV_NORMAL_CYC) : CNT_W'(CONV_FAST_CYC);
  wire conv_done   = (state_ff == PDCMC_CONV) &&
                     (cnt_ff == conv_len - CNT_W'(1));
  wire eoc         = conv_done && !hold_off;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      PDCMC_SLEEP: begin
        if (!sleep_s) begin
          nxt_state = PDCMC_IDLE;
        end
      end
      PDCMC_IDLE: begin
        if (sleep_s) begin
          nxt_state = PDCMC_SLEEP;
        end else if (start_rise && !creset_s) begin
          nxt_state = PDCMC_CONV;
          nxt_cnt   = '0;
        end
      end
      PDCMC_CONV: begin
        if (sleep_s) begin
          nxt_state = PDCMC_SLEEP;
        end else if (creset_s || conv_done) begin
          nxt_state = PDCMC_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      default: begin
        nxt_state = PDCMC_SLEEP;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= PDCMC_SLEEP;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // configuration pipeline: captured word applies at the next end
  always_ff @(posedge i_clk) begin
    if (i_rst || creset_s) begin
      cfg_ff      <= CFG_RESET;
      pend_ff     <= CFG_RESET;
      pend_vld_ff <= 1'b0;
    end else begin
      if (eoc && pend_vld_ff) begin
        cfg_ff <= pend_ff;
      end
      if (i_cfg.valid && !sleep_s) begin
        pend_ff     <= i_cfg.word;
        pend_vld_ff <= 1'b1;
      end else if (eoc) begin
        pend_vld_ff <= 1'b0;
      end
    end
  end

  // fast-mode idle watch: flags a gap longer than the limit
  always_ff @(posedge i_clk) begin
    if (i_rst || creset_s || sleep_s) begin
      idle_ff    <= '0;
      overrun_ff <= 1'b0;
    end else if (state_ff == PDCMC_CONV || timing_sel) begin
      idle_ff    <= '0;
      overrun_ff <= 1'b0;
    end else if (idle_ff != CNT_W'(IDLE_MAX_CYC)) begin
      idle_ff    <= idle_ff + CNT_W'(1);
    end else begin
      overrun_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      kill_ff <= 1'b1;
    end else begin
      busy_ff <= (nxt_state == PDCMC_CONV);
      kill_ff <= abort_rise | hold_off;
    end
  end

  assign o_conversion_active_output = busy_ff;
  assign o_serial_enable            = ~kill_ff;
  assign o_data_out_oe_kill         = kill_ff;
  assign o_conversion_timing_select = timing_sel;
  assign o_idle_overrun             = overrun_ff;
  assign o_cfg_active               = cfg_ff;

  always_comb begin
    o_power.analog_regulator_output    = state_ff != PDCMC_SLEEP;
    o_power.digital_regulator_output   = state_ff != PDCMC_SLEEP;
    o_power.reference_regulator_output = state_ff != PDCMC_SLEEP;
    o_power.reference_enable           = state_ff != PDCMC_SLEEP;
  end
endmodule

// ==== verif/pdcmc_host.sv ====
/* pdcmc_host: host model driving sleep, core reset, start and config.
   assumes the bench clock; pins change on falling edges only. */
module pdcmc_host
  import pdcmc_pkg::*;
(
  input  wire logic i_clk,
  output logic       o_sleep,
  output logic       o_core_rst,
  output logic       o_start,
  output pdcmc_cfg_s o_cfg
);
  initial begin
    o_sleep    = 1'b1;
    o_core_rst = 1'b1;
    o_start    = 1'b0;
    o_cfg      = '0;
  end
  task automatic pins(input logic s, input logic r);
    @(negedge i_clk);
    o_sleep    = s;
    o_core_rst = r;
  endtask
  task automatic start();
    @(negedge i_clk) o_start = 1'b1;
    repeat (8) @(negedge i_clk);
    o_start = 1'b0;
  endtask
  // word lines scrambled once valid drops
  task automatic word(input logic [15:0] w);
    @(negedge i_clk) o_cfg = '{1'b1, w};
    @(negedge i_clk) o_cfg = '{1'b0, ~w};
  endtask
endmodule

// ==== verif/pdcmc_checker.sv ====
/* pdcmc_checker: timing relations of pdcmc_ctrl at its ports.
   assumes one clock and the synchronous block reset. */
module pdcmc_checker
  import pdcmc_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_sleep_request_input,
  input wire logic        i_core_reset,
  input wire logic        i_sample_start_input,
  input wire pdcmc_cfg_s  i_cfg,
  input wire logic        o_conversion_active_output,
  input wire logic        o_serial_enable,
  input wire logic        o_data_out_oe_kill,
  input wire logic        o_conversion_timing_select,
  input wire logic        o_idle_overrun,
  input wire logic [15:0] o_cfg_active,
  input wire pdcmc_power_s o_power
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic       busy;
  logic       pin;
  logic [5:0] hist_ff;
  logic [15:0] len_ff;
  logic       hit_ff;
  assign busy = o_conversion_active_output;
  assign pin  = i_sleep_request_input | i_core_reset;
  always_ff @(posedge i_clk) begin
    hist_ff <= {hist_ff[4:0], pin};
    len_ff  <= busy ? len_ff + 16'h0001 : 16'h0000;
    hit_ff  <= busy & (hit_ff | pin);
  end
  a_sleep_power_off: assert property (i_sleep_request_input [*5] |->
    o_power == '0) else $error("power on in sleep");
  a_sleep_is_quiet: assert property (i_sleep_request_input [*5] |->
    !o_serial_enable && !$rose(busy)) else $error("active in sleep");
  a_abort_on_rise: assert property ($rose(pin) |-> ##[1:5]
    (o_data_out_oe_kill && !busy)) else $error("no abort");
  a_reset_normal: assert property (i_core_reset [*5] |->
    o_cfg_active == CFG_RESET) else $error("cfg not default");
  a_conv_length: assert property ($fell(busy) && !hit_ff |-> len_ff ==
    ($past(o_conversion_timing_select) ? CONV_NORMAL_CYC : CONV_FAST_CYC))
    else $error("busy length wrong");
  a_cfg_at_eoc: assert property ($changed(o_cfg_active) |->
    $fell(busy) || (|hist_ff)) else $error("cfg changed early");
  a_start_synced: assert property ($rose(busy) |->
    $past(i_sample_start_input, 2)) else $error("start unsynced");
  a_start_taken: assert property ($rose(i_sample_start_input) && !busy &&
    !o_data_out_oe_kill && {hist_ff, pin} == '0 |-> ##[2:6] busy)
    else $error("start missed");
  a_mode_bit: assert property (o_conversion_timing_select ==
    o_cfg_active[CFG_TIMING_BIT]) else $error("mode bit wrong");
  a_overrun_fast: assert property ($rose(o_idle_overrun) |->
    !o_conversion_timing_select) else $error("overrun normal");
  c_fast: cover property ($fell(busy) && !o_conversion_timing_select);
  c_abort: cover property ($fell(busy) && hit_ff);
  c_overrun: cover property ($rose(o_idle_overrun));
endmodule
bind pdcmc_ctrl pdcmc_checker chk_u (.*);

// ==== verif/pdcmc_tb_top.sv ====
/* pdcmc_tb_top: self-checking bench for pdcmc_ctrl with a host model.
   assumes the package defaults for conversion and idle lengths. */
module pdcmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pdcmc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sleep, crst, start, busy, ser, kill, tsel, ovr;
  logic [15:0] act;
  pdcmc_cfg_s cfg;
  pdcmc_power_s pwr;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #4 i_clk = ~i_clk;
  pdcmc_host host_u (.i_clk(i_clk), .o_sleep(sleep), .o_core_rst(crst),
    .o_start(start), .o_cfg(cfg));
  pdcmc_ctrl dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_sleep_request_input(sleep), .i_core_reset(crst),
    .i_sample_start_input(start), .i_cfg(cfg),
    .o_conversion_active_output(busy), .o_serial_enable(ser),
    .o_data_out_oe_kill(kill), .o_conversion_timing_select(tsel),
    .o_idle_overrun(ovr), .o_cfg_active(act), .o_power(pwr));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // start one conversion and count the cycles busy stays high
  task automatic conv(input int n);
    int c;
    fork host_u.start(); join_none
    for (c = 0; c < 20 && busy !== 1'b1; c++) @(negedge i_clk);
    for (c = 0; c < 999 && busy === 1'b1; c++) @(negedge i_clk);
    check(c, n);
  endtask
  task automatic wake();
    host_u.pins(1'b0, 1'b1);
    repeat (20) @(negedge i_clk);
    host_u.pins(1'b0, 1'b0);
    repeat (10) @(negedge i_clk);
    check(pwr, 16'h000f);
    check(act, CFG_RESET);
    check(tsel, 16'h0001);
  endtask
  task automatic mode_switch();
    host_u.word(16'h0000);
    repeat (4) @(negedge i_clk);
    check(act, CFG_RESET);
    conv(CONV_NORMAL_CYC);
    check(act, 16'h0000);
    check(tsel, 16'h0000);
    conv(CONV_FAST_CYC);
    repeat (IDLE_MAX_CYC + 20) @(negedge i_clk);
    check(ovr, 16'h0001);
    conv(CONV_FAST_CYC);
    check(ovr, 16'h0000);
  endtask
  task automatic sleep_abort();
    fork host_u.start(); join_none
    repeat (30) @(negedge i_clk);
    host_u.pins(1'b1, 1'b0);
    repeat (8) @(negedge i_clk);
    check({busy, kill, ser}, 16'h0002);
    check(pwr, 16'h0000);
    host_u.start();
    repeat (8) @(negedge i_clk);
    check(busy, 16'h0000);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_rst = 1'b0;
    wake();
    conv(CONV_NORMAL_CYC);
    mode_switch();
    sleep_abort();
    wake();
    conv(CONV_NORMAL_CYC);
    results();
  end
endmodule
